// ---- logic/bht_pkg.sv ----
// Shared constants and types for the two-wire bus hang time-out block.
`default_nettype none
package bht_pkg;
    // Device register addresses on the link.
    localparam logic [7:0] BHT_TOC_ADDR       = 8'hBF;
    localparam logic [7:0] BHT_EVT_ADDR       = 8'hC0;
    localparam logic [7:0] BHT_CODE_ADDR      = 8'hC1;
    localparam logic [7:0] BHT_IEN_ADDR       = 8'hC2;
    // Field positions of the device registers.
    localparam int         BHT_TOC_FLAG_BIT   = 0;
    localparam int         BHT_TOC_DIV_BIT    = 1;
    localparam int         BHT_TOC_EN_BIT     = 2;
    localparam int         BHT_EVT_SI_BIT     = 0;
    localparam int         BHT_EVT_STOP_BIT   = 1;
    localparam int         BHT_IEN_MASK_BIT   = 0;
    localparam int         BHT_IEN_GLOBAL_BIT = 1;
    // Reset values and state codes.
    localparam logic [7:0] BHT_REG_RESET      = 8'h00;
    localparam logic [7:0] BHT_CODE_IDLE      = 8'hF8;
    localparam logic [7:0] BHT_CODE_BUS_ERR   = 8'h00;
    // Counter geometry: 14 bits, slow rate divides by four.
    localparam int         BHT_CNT_W          = 14;
    localparam logic [1:0] BHT_SLOW_DIV_LAST  = 2'h3;
    // Controller word indexes on the bus (byte address is four times).
    localparam logic [2:0] BHT_WB_CMD_IDX     = 3'h0;
    localparam logic [2:0] BHT_WB_STATUS_IDX  = 3'h1;
    localparam logic [2:0] BHT_WB_ISTAT_IDX   = 3'h2;
    localparam logic [2:0] BHT_WB_IEN_IDX     = 3'h3;
    localparam logic [2:0] BHT_WB_ICLR_IDX    = 3'h4;
    // Controller fields.
    localparam int         BHT_CMD_WE_BIT     = 16;
    localparam int         BHT_ST_BUSY_BIT    = 8;
    localparam int         BHT_ST_IRQ_BIT     = 9;
    localparam int         BHT_EV_DONE_BIT    = 0;
    localparam int         BHT_EV_IRQ_BIT     = 1;
    localparam int         BHT_EV_W           = 2;
    // Controller sequencer states.
    typedef enum logic [0:0] {
        BHT_CTL_IDLE = 1'b0,
        BHT_CTL_WAIT = 1'b1
    } bht_ctl_state_t;
endpackage
`default_nettype wire

// ---- logic/bht_link_if.sv ----
// Link between the controller and the time-out device register port.
`timescale 1ns/10ps
`default_nettype none
interface bht_link_if;
    logic       req;
    logic       we;
    logic [7:0] addr;
    logic [7:0] wdata;
    logic       ack;
    logic [7:0] rdata;
    logic       irq;
    // Device end answers accesses and raises the shared request.
    modport dev (input req, we, addr, wdata, output ack, rdata, irq);
    // Controller end issues accesses.
    modport ctl (output req, we, addr, wdata, input ack, rdata, irq);
endinterface
`default_nettype wire

// ---- logic/bht_hang_counter.sv ----
// Prescaled hang counter that flags a wrap from all ones to zero.
`timescale 1ns/10ps
`default_nettype none
module bht_hang_counter
    import bht_pkg::*;
#(
    parameter int CNT_W = BHT_CNT_W
) (
    // Clock and reset.
    input  wire logic clk_sys_i,
    input  wire logic reset_i,
    // Control.
    input  wire logic enable_i,
    input  wire logic hold_i,
    input  wire logic quarter_i,
    // Result.
    output logic      overflow_o
);
    logic [1:0]       pre_ff;
    logic [1:0]       nxt_pre;
    logic [CNT_W-1:0] cnt_ff;
    logic [CNT_W-1:0] nxt_cnt;
    logic             tick;

    if (CNT_W < 2) begin : g_bad_width
        $error("Counter width must be at least two.");
    end

    // Slow rate advances once per four system clocks.
    assign tick       = !quarter_i || (pre_ff == BHT_SLOW_DIV_LAST);
    assign overflow_o = enable_i && !hold_i && tick && (&cnt_ff);

    // Disable or a pending event keeps the count at zero, so counting restarts fresh.
    always_comb begin
        nxt_pre = pre_ff;
        nxt_cnt = cnt_ff;
        if (!enable_i) begin
            nxt_pre = '0;
            nxt_cnt = '0;
        end else if (hold_i) begin
            nxt_pre = '0;
            nxt_cnt = '0;
        end else begin
            nxt_pre = pre_ff + 2'h1;
            if (tick) begin
                nxt_cnt = cnt_ff + 1'b1;
            end
        end
    end

    // Registers.
    always_ff @(posedge clk_sys_i) begin
        if (reset_i) begin
            pre_ff <= '0;
            cnt_ff <= '0;
        end else begin
            pre_ff <= nxt_pre;
            cnt_ff <= nxt_cnt;
        end
    end
endmodule // bht_hang_counter
`default_nettype wire

// ---- logic/bht_dev_end.sv ----
// Device end: time-out register, serial event flag and shared interrupt.
//
// Chosen here: the link register port.
`timescale 1ns/10ps
`default_nettype none
module bht_dev_end
    import bht_pkg::*;
#(
    parameter int CNT_W = BHT_CNT_W
) (
    // Clock and reset.
    input  wire logic       clk_sys_i,
    input  wire logic       reset_i,
    // Register link from the controller.
    bht_link_if.dev         link,
    // Serial engine events.
    input  wire logic       engine_event_i,
    input  wire logic [7:0] engine_code_i,
    input  wire logic       bus_error_i,
    input  wire logic       stop_sent_i,
    input  wire logic       addressed_i,
    // Engine controls and visible state.
    output logic            lines_release_o,
    output logic            slave_addressed_o,
    output logic            serial_flag_o,
    output logic            stop_request_o,
    output logic            timeout_flag_o
);
    logic       ack_ff, nxt_ack;
    logic [7:0] rdata_ff, nxt_rdata;
    logic       irq_ff, nxt_irq;
    logic       hang_counter_enable_ff, nxt_hang_counter_enable;
    logic       quarter_ff, nxt_quarter;
    logic       hang_overflow_flag_ff, nxt_hang_overflow_flag;
    logic       serial_flag_ff, nxt_serial_flag;
    logic       stop_request_ff, nxt_stop_request;
    logic       err_ff, nxt_err;
    logic       addressed_ff, nxt_addressed;
    logic [7:0] bus_state_code_ff, nxt_bus_state_code;
    logic       twowire_irq_mask_ff, nxt_twowire_irq_mask;
    logic       global_irq_enable_ff, nxt_global_irq_enable;
    logic       take;
    logic       wr;
    logic       overflow;

    if (CNT_W < 2) begin : g_bad_width
        $error("Counter width must be at least two.");
    end

    // The counter runs from the system clock and is held by the event flag.
    bht_hang_counter #(
        .CNT_W      (CNT_W)
    ) u_counter (
        .clk_sys_i  (clk_sys_i),
        .reset_i    (reset_i),
        .enable_i   (hang_counter_enable_ff),
        .hold_i     (serial_flag_ff),
        .quarter_i  (quarter_ff),
        .overflow_o (overflow)
    );

    // An access is taken once; the ack cycle blocks a second take of the same request.
    assign take = link.req && !ack_ff;
    assign wr   = take && link.we;

    // Register reads, answered one cycle after the take.
    always_comb begin
        nxt_ack   = take;
        nxt_rdata = BHT_REG_RESET;
        if (take && !link.we) begin
            case (link.addr)
                BHT_TOC_ADDR: begin
                    nxt_rdata[BHT_TOC_EN_BIT]   = hang_counter_enable_ff;
                    nxt_rdata[BHT_TOC_DIV_BIT]  = quarter_ff;
                    nxt_rdata[BHT_TOC_FLAG_BIT] = hang_overflow_flag_ff;
                end
                BHT_EVT_ADDR: begin
                    nxt_rdata[BHT_EVT_SI_BIT]   = serial_flag_ff;
                    nxt_rdata[BHT_EVT_STOP_BIT] = stop_request_ff;
                end
                BHT_CODE_ADDR: begin
                    nxt_rdata = bus_state_code_ff;
                end
                BHT_IEN_ADDR: begin
                    nxt_rdata[BHT_IEN_MASK_BIT]   = twowire_irq_mask_ff;
                    nxt_rdata[BHT_IEN_GLOBAL_BIT] = global_irq_enable_ff;
                end
                default: begin
                    nxt_rdata = BHT_REG_RESET;
                end
            endcase
        end
    end

    // Time-out control. A hardware set beats a software clear in the same cycle.
    always_comb begin
        nxt_hang_counter_enable = hang_counter_enable_ff;
        nxt_quarter             = quarter_ff;
        nxt_hang_overflow_flag  = hang_overflow_flag_ff;
        if (wr && link.addr == BHT_TOC_ADDR) begin
            nxt_hang_counter_enable = link.wdata[BHT_TOC_EN_BIT];
            nxt_quarter             = link.wdata[BHT_TOC_DIV_BIT];
            nxt_hang_overflow_flag  = link.wdata[BHT_TOC_FLAG_BIT];
        end
        if (overflow) begin
            nxt_hang_overflow_flag = 1'b1;
        end
    end

    // Serial event flag, stop request and bus error recovery.
    always_comb begin
        nxt_serial_flag    = serial_flag_ff;
        nxt_stop_request   = stop_request_ff;
        nxt_err            = err_ff;
        nxt_addressed      = addressed_ff;
        nxt_bus_state_code = bus_state_code_ff;
        if (wr && link.addr == BHT_EVT_ADDR) begin
            nxt_serial_flag  = link.wdata[BHT_EVT_SI_BIT];
            nxt_stop_request = link.wdata[BHT_EVT_STOP_BIT];
        end else if (stop_request_ff && (stop_sent_i || (err_ff && !serial_flag_ff))) begin
            // Recovery from an error releases the bus without a real stop waveform.
            nxt_stop_request = 1'b0;
            nxt_err          = 1'b0;
        end
        if (addressed_i) begin
            nxt_addressed = 1'b1;
        end
        if (engine_event_i) begin
            nxt_serial_flag    = 1'b1;
            nxt_bus_state_code = engine_code_i;
        end
        if (bus_error_i) begin
            nxt_serial_flag    = 1'b1;
            nxt_err            = 1'b1;
            nxt_addressed      = 1'b0;
            nxt_bus_state_code = BHT_CODE_BUS_ERR;
        end
    end

    // Interrupt gating. Either flag may be the cause; software tells them apart.
    always_comb begin
        nxt_twowire_irq_mask  = twowire_irq_mask_ff;
        nxt_global_irq_enable = global_irq_enable_ff;
        if (wr && link.addr == BHT_IEN_ADDR) begin
            nxt_twowire_irq_mask  = link.wdata[BHT_IEN_MASK_BIT];
            nxt_global_irq_enable = link.wdata[BHT_IEN_GLOBAL_BIT];
        end
        nxt_irq = (serial_flag_ff || hang_overflow_flag_ff)
                  && twowire_irq_mask_ff && global_irq_enable_ff;
    end

    // Registers.
    always_ff @(posedge clk_sys_i) begin
        if (reset_i) begin
            ack_ff                 <= 1'b0;
            rdata_ff               <= BHT_REG_RESET;
            irq_ff                 <= 1'b0;
            hang_counter_enable_ff <= 1'b0;
            quarter_ff             <= 1'b0;
            hang_overflow_flag_ff  <= 1'b0;
            serial_flag_ff         <= 1'b0;
            stop_request_ff        <= 1'b0;
            err_ff                 <= 1'b0;
            addressed_ff           <= 1'b0;
            bus_state_code_ff      <= BHT_CODE_IDLE;
            twowire_irq_mask_ff    <= 1'b0;
            global_irq_enable_ff   <= 1'b0;
        end else begin
            ack_ff                 <= nxt_ack;
            rdata_ff               <= nxt_rdata;
            irq_ff                 <= nxt_irq;
            hang_counter_enable_ff <= nxt_hang_counter_enable;
            quarter_ff             <= nxt_quarter;
            hang_overflow_flag_ff  <= nxt_hang_overflow_flag;
            serial_flag_ff         <= nxt_serial_flag;
            stop_request_ff        <= nxt_stop_request;
            err_ff                 <= nxt_err;
            addressed_ff           <= nxt_addressed;
            bus_state_code_ff      <= nxt_bus_state_code;
            twowire_irq_mask_ff    <= nxt_twowire_irq_mask;
            global_irq_enable_ff   <= nxt_global_irq_enable;
        end
    end

    // Outputs straight from flip-flops.
    assign link.ack          = ack_ff;
    assign link.rdata        = rdata_ff;
    assign link.irq          = irq_ff;
    assign lines_release_o   = err_ff;
    assign slave_addressed_o = addressed_ff;
    assign serial_flag_o     = serial_flag_ff;
    assign stop_request_o    = stop_request_ff;
    assign timeout_flag_o    = hang_overflow_flag_ff;
endmodule // bht_dev_end
`default_nettype wire

// ---- logic/bht_ctl_end.sv ----
// Controller end: Wishbone slave that turns commands into link accesses.
`timescale 1ns/10ps
`default_nettype none
module bht_ctl_end
    import bht_pkg::*;
(
    // Clock and reset.
    input  wire logic        clk_sys_i,
    input  wire logic        reset_i,
    // Wishbone classic slave.
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    input  wire logic        wb_we_i,
    input  wire logic [4:0]  wb_adr_i,
    input  wire logic [3:0]  wb_sel_i,
    input  wire logic [31:0] wb_dat_i,
    output logic [31:0]      wb_dat_o,
    output logic             wb_ack_o,
    output logic             irq_o,
    // Link to the device end.
    bht_link_if.ctl          link
);
    bht_ctl_state_t        state_ff, nxt_state;
    logic                  ack_ff, nxt_ack;
    logic [31:0]           dat_ff, nxt_dat;
    logic                  req_ff, nxt_req;
    logic                  we_ff, nxt_we;
    logic [7:0]            addr_ff, nxt_addr;
    logic [7:0]            wdata_ff, nxt_wdata;
    logic [7:0]            last_ff, nxt_last;
    logic                  irq_prev_ff;
    logic [BHT_EV_W-1:0]   stat_ff, nxt_stat, en_ff, nxt_en, ev;
    logic                  irq_ff, nxt_irq;
    logic                  wb_take;
    logic [2:0]            idx;

    assign wb_take = wb_cyc_i && wb_stb_i && !ack_ff;
    assign idx     = wb_adr_i[4:2];

    // Bus answers one cycle after the take; unmapped words read zero.
    always_comb begin
        nxt_ack = wb_take;
        nxt_dat = '0;
        if (wb_take && !wb_we_i) begin
            case (idx)
                BHT_WB_CMD_IDX:    nxt_dat = {15'h0000, we_ff, addr_ff, wdata_ff};
                BHT_WB_STATUS_IDX: nxt_dat = {22'h000000, link.irq, req_ff, last_ff};
                BHT_WB_ISTAT_IDX:  nxt_dat = {{(32-BHT_EV_W){1'b0}}, stat_ff};
                BHT_WB_IEN_IDX:    nxt_dat = {{(32-BHT_EV_W){1'b0}}, en_ff};
                default:           nxt_dat = '0;
            endcase
        end
    end

    // Command sequencer. A command written while busy is dropped.
    always_comb begin
        nxt_state = state_ff;
        nxt_req   = req_ff;
        nxt_we    = we_ff;
        nxt_addr  = addr_ff;
        nxt_wdata = wdata_ff;
        nxt_last  = last_ff;
        ev        = '0;
        case (state_ff)
            BHT_CTL_IDLE: begin
                if (wb_take && wb_we_i && idx == BHT_WB_CMD_IDX && (&wb_sel_i[2:0])) begin
                    nxt_req   = 1'b1;
                    nxt_we    = wb_dat_i[BHT_CMD_WE_BIT];
                    nxt_addr  = wb_dat_i[15:8];
                    nxt_wdata = wb_dat_i[7:0];
                    nxt_state = BHT_CTL_WAIT;
                end
            end
            BHT_CTL_WAIT: begin
                if (link.ack) begin
                    nxt_req   = 1'b0;
                    nxt_last  = we_ff ? last_ff : link.rdata;
                    ev[BHT_EV_DONE_BIT] = 1'b1;
                    nxt_state = BHT_CTL_IDLE;
                end
            end
            default: begin
                nxt_req   = 1'b0;
                nxt_state = BHT_CTL_IDLE;
            end
        endcase
        ev[BHT_EV_IRQ_BIT] = link.irq && !irq_prev_ff;
    end

    // Sticky status: a new event wins over a clear in the same cycle.
    always_comb begin
        nxt_stat = stat_ff;
        nxt_en   = en_ff;
        if (wb_take && wb_we_i && wb_sel_i[0] && idx == BHT_WB_ICLR_IDX) begin
            nxt_stat = stat_ff & ~wb_dat_i[BHT_EV_W-1:0];
        end
        if (wb_take && wb_we_i && wb_sel_i[0] && idx == BHT_WB_IEN_IDX) begin
            nxt_en = wb_dat_i[BHT_EV_W-1:0];
        end
        nxt_stat = nxt_stat | ev;
        nxt_irq  = |(stat_ff & en_ff);
    end

    // Registers.
    always_ff @(posedge clk_sys_i) begin
        if (reset_i) begin
            state_ff    <= BHT_CTL_IDLE;
            ack_ff      <= 1'b0;
            dat_ff      <= '0;
            req_ff      <= 1'b0;
            we_ff       <= 1'b0;
            addr_ff     <= BHT_REG_RESET;
            wdata_ff    <= BHT_REG_RESET;
            last_ff     <= BHT_REG_RESET;
            irq_prev_ff <= 1'b0;
            stat_ff     <= '0;
            en_ff       <= '0;
            irq_ff      <= 1'b0;
        end else begin
            state_ff    <= nxt_state;
            ack_ff      <= nxt_ack;
            dat_ff      <= nxt_dat;
            req_ff      <= nxt_req;
            we_ff       <= nxt_we;
            addr_ff     <= nxt_addr;
            wdata_ff    <= nxt_wdata;
            last_ff     <= nxt_last;
            irq_prev_ff <= link.irq;
            stat_ff     <= nxt_stat;
            en_ff       <= nxt_en;
            irq_ff      <= nxt_irq;
        end
    end

    // Outputs straight from flip-flops.
    assign wb_ack_o   = ack_ff;
    assign wb_dat_o   = dat_ff;
    assign irq_o      = irq_ff;
    assign link.req   = req_ff;
    assign link.we    = we_ff;
    assign link.addr  = addr_ff;
    assign link.wdata = wdata_ff;
endmodule // bht_ctl_end
`default_nettype wire

// ---- verification/bht_link_properties.sv ----
// Checker for the link between the controller end and the device end.
`timescale 1ns/10ps
`default_nettype none
module bht_link_properties
    import bht_pkg::*;
(
    // Clock and reset.
    input wire logic       clk_sys_i,
    input wire logic       reset_i,
    // Link signals.
    input wire logic       req,
    input wire logic       we,
    input wire logic [7:0] addr,
    input wire logic [7:0] wdata,
    input wire logic       ack,
    input wire logic [7:0] rdata,
    input wire logic       irq
);
    default clocking cb @(posedge clk_sys_i);
    endclocking
    default disable iff (reset_i);

    logic ien_ok_ff;
    logic nxt_ien_ok;
    logic tof_seen_ff;
    logic nxt_tof_seen;

    // Shadows of the request enables and of a seen overflow flag, taken from link traffic.
    always_comb begin
        nxt_ien_ok = ien_ok_ff;
        nxt_tof_seen = tof_seen_ff;
        if (req && we && addr == BHT_IEN_ADDR) begin
            nxt_ien_ok = (wdata[1:0] == 2'h3);
        end
        if (req && we && addr == BHT_TOC_ADDR) begin
            nxt_tof_seen = 1'b0;
        end else if (ack && !we && addr == BHT_TOC_ADDR) begin
            nxt_tof_seen = rdata[0];
        end
    end

    // Registered shadows; reset drops both, just as it clears the device.
    always_ff @(posedge clk_sys_i) begin
        if (reset_i) begin
            ien_ok_ff <= 1'b0;
            tof_seen_ff <= 1'b0;
        end else begin
            ien_ok_ff <= nxt_ien_ok;
            tof_seen_ff <= nxt_tof_seen;
        end
    end

    ack_pulse_a: assert property (ack |=> !ack)
        else $error("link ack lasted more than one cycle");
    ack_timely_a: assert property (req && !ack |=> ack)
        else $error("link ack did not follow a taken request");
    ack_cause_a: assert property (ack |-> $past(req) && !$past(ack))
        else $error("link ack without a pending request");
    req_hold_a: assert property (req && !ack |=> req && $stable({we, addr, wdata}))
        else $error("link request changed before its ack");
    req_release_a: assert property (ack |=> !req)
        else $error("link request not released after ack");
    rdata_idle_a: assert property ((!ack || we) |-> rdata == 8'h00)
        else $error("link read data not zero outside a read ack");
    unmapped_read_a: assert property (ack && !we && !(addr inside {8'hBF, 8'hC0, 8'hC1, 8'hC2})
        |-> rdata == 8'h00)
        else $error("unmapped device address read nonzero");
    toc_reserved_a: assert property (ack && !we && addr == BHT_TOC_ADDR |-> rdata[7:3] == 5'h00)
        else $error("reserved time-out bits read nonzero");
    irq_gate_a: assert property (irq |-> ien_ok_ff || $past(ien_ok_ff) || $past(ien_ok_ff, 2) || $past(ien_ok_ff, 3))
        else $error("shared request raised while masked");
    flag_kept_a: assert property (ack && !we && addr == BHT_TOC_ADDR && tof_seen_ff |-> rdata[0])
        else $error("overflow flag dropped without a software write");
endmodule // bht_link_properties
`default_nettype wire

// ---- verification/twowire_bus_hang_timeout_test.sv ----
// Self-checking bench for the bus hang time-out controller and device ends.
`timescale 1ns/10ps
`default_nettype none
`define CHK(what, exp, got) begin n_compared++; if ((got) !== (exp)) begin error_cnt++; \
    $display("mismatch %s expected %0h seen %0h", what, exp, got); end end
module twowire_bus_hang_timeout_test
    import bht_pkg::*;
    ();
    localparam int CW = 4;
    logic        clk_sys = 1'b0;
    logic        reset = 1'b1;
    logic        wb_cyc = 1'b0;
    logic        wb_stb = 1'b0;
    logic        wb_we = 1'b0;
    logic [4:0]  wb_adr = 5'h00;
    logic [31:0] wb_dat_w = 32'h0;
    logic [31:0] wb_dat_r;
    logic        wb_ack;
    logic        irq;
    logic [3:0]  eng = 4'h0;
    logic [7:0]  code_in = 8'h00;
    logic        rel, addrd, sflag, stopreq, tflag;
    int          error_cnt = 0;
    int          n_compared = 0;
    int          d;
    logic [7:0]  q;
    logic [31:0] r;
    realtime     t_wr = 0;

    // Free-running system clock.
    always #5 clk_sys = ~clk_sys;

    bht_link_if lnk ();
    bht_ctl_end i_bht_ctl_end (.clk_sys_i(clk_sys), .reset_i(reset), .wb_cyc_i(wb_cyc),
        .wb_stb_i(wb_stb), .wb_we_i(wb_we), .wb_adr_i(wb_adr), .wb_sel_i(4'hF),
        .wb_dat_i(wb_dat_w), .wb_dat_o(wb_dat_r), .wb_ack_o(wb_ack), .irq_o(irq), .link(lnk.ctl));
    bht_dev_end #(.CNT_W(CW)) i_bht_dev_end (.clk_sys_i(clk_sys), .reset_i(reset),
        .link(lnk.dev), .engine_event_i(eng[0]), .engine_code_i(code_in), .bus_error_i(eng[1]),
        .stop_sent_i(eng[2]), .addressed_i(eng[3]), .lines_release_o(rel),
        .slave_addressed_o(addrd), .serial_flag_o(sflag), .stop_request_o(stopreq),
        .timeout_flag_o(tflag));
    bht_link_properties i_bht_link_properties (.clk_sys_i(clk_sys), .reset_i(reset),
        .req(lnk.req), .we(lnk.we), .addr(lnk.addr), .wdata(lnk.wdata), .ack(lnk.ack),
        .rdata(lnk.rdata), .irq(lnk.irq));

    // Stamp each completed link write, so counts are measured from the moment it lands.
    always @(posedge clk_sys) begin
        if (lnk.req && lnk.ack && lnk.we) begin
            t_wr = $realtime;
        end
    end

    task automatic complete_run;
        $display("counts: %0d compared, %0d mismatches", n_compared, error_cnt);
        if (error_cnt == 0 && n_compared > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    // One classic Wishbone cycle; the request is held until ack is sampled.
    task automatic wb_xfer(input logic w, input logic [4:0] a, input logic [31:0] dw,
                           output logic [31:0] rd);
        int n;
        n = 0;
        @(posedge clk_sys);
        wb_cyc <= 1'b1;
        wb_stb <= 1'b1;
        wb_we <= w;
        wb_adr <= a;
        wb_dat_w <= dw;
        do begin
            @(posedge clk_sys);
            n++;
        end while (wb_ack !== 1'b1 && n < 40);
        rd = wb_dat_r;
        wb_cyc <= 1'b0;
        wb_stb <= 1'b0;
        wb_we <= 1'b0;
        if (n >= 40) `CHK("wb ack", 1'b1, 1'b0)
    endtask

    // Device access through the command word, then poll busy; low byte is the read data.
    task automatic dev(input logic w, input logic [7:0] a, input logic [7:0] dw);
        int n;
        wb_xfer(1'b1, {BHT_WB_CMD_IDX, 2'b00}, {15'h0000, w, a, dw}, r);
        n = 0;
        do begin
            wb_xfer(1'b0, {BHT_WB_STATUS_IDX, 2'b00}, 32'h0, r);
            n++;
        end while (r[BHT_ST_BUSY_BIT] !== 1'b0 && n < 20);
        if (n >= 20) `CHK("link busy", 1'b0, 1'b1)
        q = r[7:0];
    endtask

    task automatic dchk(input logic [7:0] a, input logic [7:0] e, input string s);
        dev(1'b0, a, 8'h00);
        `CHK(s, e, q)
    endtask

    task automatic wchk(input logic [4:0] a, input logic [31:0] e, input string s);
        wb_xfer(1'b0, a, 32'h0, r);
        `CHK(s, e, r)
    endtask

    // Engine pulse of one cycle; the extra edge lets the registered outputs settle.
    task automatic pulse(input logic [3:0] m);
        @(posedge clk_sys);
        eng <= m;
        @(posedge clk_sys);
        eng <= 4'h0;
        @(posedge clk_sys);
    endtask

    // Cycles from the last link write until the overflow flag is seen, bounded.
    task automatic wait_flag;
        int c;
        c = 0;
        while (tflag !== 1'b1 && c < 300) begin
            @(posedge clk_sys);
            c++;
        end
        d = int'(($realtime - t_wr) / 10.0);
    endtask

    // A hang anywhere ends the run through the same closing task.
    initial begin
        repeat (20000) @(posedge clk_sys);
        error_cnt++;
        complete_run();
    end

    initial begin
        repeat (16) @(posedge clk_sys);
        reset <= 1'b0;
        dchk(BHT_TOC_ADDR, 8'h00, "toc reset");
        dchk(BHT_EVT_ADDR, 8'h00, "event reset");
        dchk(BHT_CODE_ADDR, BHT_CODE_IDLE, "code reset");
        dchk(BHT_IEN_ADDR, 8'h00, "enable reset");
        dchk(8'h10, 8'h00, "unmapped device read");
        wchk(5'h14, 32'h0, "unmapped bus read");
        $display("test reset values done");
        dev(1'b1, BHT_TOC_ADDR, 8'h04);
        wait_flag();
        `CHK("full rate overflow", 1'b1, (d >= 16 && d <= 20))
        repeat (40) @(posedge clk_sys);
        `CHK("flag kept", 1'b1, tflag)
        dchk(BHT_TOC_ADDR, 8'h05, "toc flag");
        dev(1'b1, BHT_TOC_ADDR, 8'h04);
        repeat (2) @(posedge clk_sys);
        dev(1'b1, BHT_TOC_ADDR, 8'h00);
        repeat (30) @(posedge clk_sys);
        `CHK("disabled no count", 1'b0, tflag)
        dev(1'b1, BHT_TOC_ADDR, 8'h04);
        wait_flag();
        `CHK("restart from zero", 1'b1, (d >= 16 && d <= 20))
        dev(1'b1, BHT_TOC_ADDR, 8'h00);
        dev(1'b1, BHT_TOC_ADDR, 8'h06);
        wait_flag();
        `CHK("quarter rate overflow", 1'b1, (d >= 64 && d <= 68))
        dev(1'b1, BHT_TOC_ADDR, 8'h00);
        $display("test counting done");
        code_in <= 8'hA8;
        pulse(4'h1);
        `CHK("serial flag", 1'b1, sflag)
        dchk(BHT_CODE_ADDR, 8'hA8, "code load");
        dev(1'b1, BHT_TOC_ADDR, 8'h04);
        repeat (40) @(posedge clk_sys);
        `CHK("held by serial flag", 1'b0, tflag)
        dev(1'b1, BHT_EVT_ADDR, 8'h00);
        wait_flag();
        `CHK("count after flag clear", 1'b1, (d >= 16 && d <= 21))
        dev(1'b1, BHT_TOC_ADDR, 8'h00);
        $display("test serial hold done");
        pulse(4'h8);
        `CHK("addressed", 1'b1, addrd)
        pulse(4'h2);
        `CHK("error state", 3'b110, {sflag, rel, addrd})
        dchk(BHT_CODE_ADDR, BHT_CODE_BUS_ERR, "error code");
        dev(1'b1, BHT_EVT_ADDR, 8'h02);
        repeat (3) @(posedge clk_sys);
        `CHK("error release", 2'b00, {stopreq, rel})
        dev(1'b1, BHT_EVT_ADDR, 8'h02);
        `CHK("stop pending", 1'b1, stopreq)
        pulse(4'h4);
        `CHK("stop sent", 1'b0, stopreq)
        $display("test bus error done");
        pulse(4'h1);
        dev(1'b1, BHT_IEN_ADDR, 8'h01);
        repeat (3) @(posedge clk_sys);
        `CHK("global off", 1'b0, lnk.irq)
        dev(1'b1, BHT_IEN_ADDR, 8'h03);
        repeat (3) @(posedge clk_sys);
        `CHK("serial request", 1'b1, lnk.irq)
        wchk({BHT_WB_ISTAT_IDX, 2'b00}, 32'h3, "status sticky");
        wb_xfer(1'b1, {BHT_WB_IEN_IDX, 2'b00}, 32'h2, r);
        repeat (2) @(posedge clk_sys);
        `CHK("irq enabled", 1'b1, irq)
        wb_xfer(1'b1, {BHT_WB_ICLR_IDX, 2'b00}, 32'h3, r);
        repeat (2) @(posedge clk_sys);
        `CHK("irq cleared", 1'b0, irq)
        dev(1'b1, BHT_EVT_ADDR, 8'h00);
        repeat (3) @(posedge clk_sys);
        `CHK("request drops", 1'b0, lnk.irq)
        dev(1'b1, BHT_TOC_ADDR, 8'h04);
        wait_flag();
        repeat (3) @(posedge clk_sys);
        `CHK("overflow request", 2'b11, {lnk.irq, irq})
        wchk({BHT_WB_STATUS_IDX, 2'b00}, 32'h200, "status link irq");
        wchk({BHT_WB_CMD_IDX, 2'b00}, {15'h0000, 1'b1, BHT_TOC_ADDR, 8'h04}, "command readback");
        wb_xfer(1'b1, {BHT_WB_IEN_IDX, 2'b00}, 32'h0, r);
        repeat (2) @(posedge clk_sys);
        `CHK("irq masked", 1'b0, irq)
        dchk(BHT_TOC_ADDR, 8'h05, "flag seen by handler");
        dchk(BHT_TOC_ADDR, 8'h05, "flag kept on reread");
        $display("test interrupts done");
        complete_run();
    end
endmodule // twowire_bus_hang_timeout_test
`default_nettype wire
